// ---- core/pwm_restart_delay.v ----
// Auto-restart policy, active-edge delay and register file of the enhanced PWM output stage
`include "pwm_restart_defs.vh"
`default_nettype none

// Notes on behaviour
// - With auto-restart on, the shutdown event flag clears itself once the shutdown condition is gone.
// - With auto-restart off, the flag holds after a shutdown until software clears it.
// - The 7-bit delay count sets how many instruction cycles an active-going edge is postponed.
// - With comparator sync enabled, shutdown entry waits for the timer's synchronizing edge.
module pwm_restart_delay (
    input  wire                 CLK,          // System clock, 200 MHz
    input  wire                 RST,          // Synchronous reset, active high
    input  wire [`ADDR_W-1:0]   ADDR,         // Register address
    input  wire [`DATA_W-1:0]   WDATA,        // Write data
    input  wire                 WR,           // Write strobe
    input  wire                 RD,           // Read strobe
    output reg  [`DATA_W-1:0]   RDATA,        // Read data, cycle after RD
    input  wire                 PWM_RAW,      // Scheduled PWM level from generator
    input  wire                 SHDN_COND,    // Shutdown condition from source select
    input  wire                 CMP_SYNC_EN,  // comparator_output_sync_enable
    input  wire                 TMR_SYNC,     // Sync edge pulse of sixteen_bit_timer
    output wire                 PWM_OUT,      // Delayed PWM to output steering
    output wire                 SHDN_STATE,   // Outputs held in shutdown state
    output wire                 IRQ           // Level interrupt
);

    reg  [`DATA_W-1:0] ctrl_r;
    reg                flag_r;
    reg                flag_nxt;
    reg                qual_r;
    reg  [`IRQ_W-1:0]  istat_r;
    reg  [`IRQ_W-1:0]  imask_r;
    wire [`IRQ_W-1:0]  ev;
    wire               tick;
    wire               edge_done;
    wire               auto_clr;
    wire               wr_event;

    function sel;
        input [`ADDR_W-1:0] a;
        input [`ADDR_W-1:0] t;
        begin
            sel = (a == t);
        end
    endfunction

    icyc_tick #(
        .DIV (`ICYC_DIV)
    ) u_tick (
        .clk  (CLK),
        .rst  (RST),
        .tick (tick)
    );

    // Comparator source sampled only on the timer edge when sync is on
    always @(posedge CLK) begin
        if (RST) begin
            qual_r <= 1'b0;
        end else if (!CMP_SYNC_EN || TMR_SYNC) begin
            qual_r <= SHDN_COND;
        end
    end

    always @(posedge CLK) begin
        if (RST) begin
            ctrl_r <= `CTRL_RESET;
        end else if (WR && sel(ADDR, `ADDR_CTRL)) begin
            ctrl_r <= WDATA;
        end
    end

    assign wr_event = WR && sel(ADDR, `ADDR_EVENT);
    assign auto_clr = ctrl_r[`CTRL_RSEN_BIT] && flag_r && !qual_r;

    // A live shutdown always wins over any clear
    always @* begin
        if (qual_r) begin
            flag_nxt = 1'b1;
        end else if (wr_event) begin
            flag_nxt = WDATA[`EVENT_FLAG_BIT];
        end else if (auto_clr) begin
            flag_nxt = 1'b0;
        end else begin
            flag_nxt = flag_r;
        end
    end

    always @(posedge CLK) begin
        if (RST) begin
            flag_r <= 1'b0;
        end else begin
            flag_r <= flag_nxt;
        end
    end

    active_edge_delay #(
        .W (`DC_W)
    ) u_delay (
        .clk   (CLK),
        .rst   (RST),
        .tick  (tick),
        .raw   (PWM_RAW),
        .count (ctrl_r[`CTRL_DC_MSB:`CTRL_DC_LSB]),
        .kill  (flag_r),
        .out   (PWM_OUT),
        .done  (edge_done)
    );

    assign SHDN_STATE = flag_r;

    assign ev[`IRQ_SHDN_ENTRY_BIT] = flag_nxt && !flag_r;
    assign ev[`IRQ_RESTART_BIT]    = flag_r && !flag_nxt;
    assign ev[`IRQ_EDGE_DONE_BIT]  = edge_done;

    // Set wins over a write-one clear in the same cycle
    always @(posedge CLK) begin
        if (RST) begin
            istat_r <= `IRQ_RESET;
            imask_r <= `IRQ_RESET;
        end else begin
            if (WR && sel(ADDR, `ADDR_ISTAT)) begin
                istat_r <= (istat_r & ~WDATA[`IRQ_W-1:0]) | ev;
            end else begin
                istat_r <= istat_r | ev;
            end
            if (WR && sel(ADDR, `ADDR_IMASK)) begin
                imask_r <= WDATA[`IRQ_W-1:0];
            end
        end
    end

    assign IRQ = |(istat_r & imask_r);

    always @(posedge CLK) begin
        if (RST) begin
            RDATA <= {`DATA_W{1'b0}};
        end else if (RD) begin
            case (ADDR)
                `ADDR_CTRL:  RDATA <= ctrl_r;
                `ADDR_EVENT: RDATA <= {{(`DATA_W-1){1'b0}}, flag_r};
                `ADDR_LIVE:  RDATA <= {{(`DATA_W-3){1'b0}}, PWM_RAW, PWM_OUT, qual_r};
                `ADDR_ISTAT: RDATA <= {{(`DATA_W-`IRQ_W){1'b0}}, istat_r};
                `ADDR_IMASK: RDATA <= {{(`DATA_W-`IRQ_W){1'b0}}, imask_r};
                default:     RDATA <= {`DATA_W{1'b0}};
            endcase
        end else begin
            RDATA <= {`DATA_W{1'b0}};
        end
    end

endmodule

`default_nettype wire

// ---- include/pwm_restart_defs.vh ----
// Register map, field positions, reset values and timing counts for the PWM restart and delay block
`ifndef PWM_RESTART_DEFS_VH
`define PWM_RESTART_DEFS_VH

`define ADDR_W              4
`define DATA_W              8

`define ADDR_CTRL           4'h0
`define ADDR_EVENT          4'h1
`define ADDR_LIVE           4'h2
`define ADDR_ISTAT          4'h3
`define ADDR_IMASK          4'h4

`define CTRL_RSEN_BIT       7
`define CTRL_DC_MSB         6
`define CTRL_DC_LSB         0
`define CTRL_RESET          8'h00

`define EVENT_FLAG_BIT      0

`define LIVE_SHDN_BIT       0
`define LIVE_PWM_BIT        1
`define LIVE_RAW_BIT        2

`define IRQ_W               3
`define IRQ_SHDN_ENTRY_BIT  0
`define IRQ_RESTART_BIT     1
`define IRQ_EDGE_DONE_BIT   2
`define IRQ_RESET           3'h0

`define ICYC_DIV            4
`define DC_W                7

`endif

// ---- core/icyc_tick.v ----
// Instruction-cycle tick generator: one pulse every DIV system clocks
`include "pwm_restart_defs.vh"
`default_nettype none

module icyc_tick #(
    parameter DIV = `ICYC_DIV
) (
    input  wire clk,   // System clock
    input  wire rst,   // Synchronous reset, active high
    output reg  tick   // One-cycle pulse per instruction cycle
);

    localparam CW = (DIV <= 2) ? 1 : $clog2(DIV);
    // Integer first, then cut to the counter width on purpose
    localparam integer  LAST_I = DIV - 1;
    localparam [CW-1:0] LAST   = LAST_I[CW-1:0];

    reg [CW-1:0] cnt_r;

    always @(posedge clk) begin
        if (rst) begin
            cnt_r <= {CW{1'b0}};
            tick  <= 1'b0;
        end else begin
            tick  <= (cnt_r == LAST);
            cnt_r <= (cnt_r == LAST) ? {CW{1'b0}} : cnt_r + 1'b1;
        end
    end

endmodule

`default_nettype wire

// ---- core/active_edge_delay.v ----
// Delays each rising edge of the scheduled PWM by a count of instruction cycles
`include "pwm_restart_defs.vh"
`default_nettype none

module active_edge_delay #(
    parameter W = `DC_W
) (
    input  wire         clk,     // System clock
    input  wire         rst,     // Synchronous reset, active high
    input  wire         tick,    // Instruction-cycle pulse
    input  wire         raw,     // Scheduled PWM level
    input  wire [W-1:0] count,   // Delay in instruction cycles
    input  wire         kill,    // Force inactive (shutdown)
    output reg          out,     // Delayed PWM level
    output reg          done     // Pulse when a delayed edge is issued
);

    reg         raw_d_r;
    reg         pend_r;
    reg [W-1:0] cnt_r;

    always @(posedge clk) begin
        if (rst) begin
            raw_d_r <= 1'b0;
            pend_r  <= 1'b0;
            cnt_r   <= {W{1'b0}};
            out     <= 1'b0;
            done    <= 1'b0;
        end else begin
            raw_d_r <= raw;
            done    <= 1'b0;
            if (kill || !raw) begin
                // Inactive edges are never delayed
                out    <= 1'b0;
                pend_r <= 1'b0;
            end else if (raw && !raw_d_r) begin
                if (count == {W{1'b0}}) begin
                    out  <= 1'b1;
                    done <= 1'b1;
                end else begin
                    cnt_r  <= count;
                    pend_r <= 1'b1;
                end
            end else if (pend_r && tick) begin
                if (cnt_r == {{(W-1){1'b0}}, 1'b1}) begin
                    out    <= 1'b1;
                    done   <= 1'b1;
                    pend_r <= 1'b0;
                end else begin
                    cnt_r <= cnt_r - 1'b1;
                end
            end
        end
    end

endmodule

`default_nettype wire

// ---- sim/power_stage_model.sv ----
// Power switch model standing on the delayed PWM drive
`default_nettype none
module power_stage_model (
    input  wire logic       clk,      // System clock
    input  wire logic       gate,     // Delayed PWM drive
    input  wire logic       hold,     // Shutdown state
    output var  logic [7:0] turn_ons  // Switch turn-on count
);
    timeunit 1ns;
    timeprecision 100ps;
    logic last = 1'b0;
    initial turn_ons = 8'h00;
    // A turn-on while held would mean a shoot-through hazard
    always @(posedge clk) begin
        last <= gate;
        if (gate && !last && !hold)
            turn_ons <= turn_ons + 8'h01;
    end
endmodule
`default_nettype wire

// ---- sim/pwm_restart_delay_assertions.sv ----
// Port assertions for the PWM restart and delay block
`default_nettype none
module pwm_restart_delay_assertions (
    input wire logic       CLK,          // System clock
    input wire logic       RST,          // Synchronous reset, active high
    input wire logic [3:0] ADDR,         // Register address
    input wire logic [7:0] WDATA,        // Write data
    input wire logic       WR,           // Write strobe
    input wire logic       RD,           // Read strobe
    input wire logic [7:0] RDATA,        // Read data
    input wire logic       PWM_RAW,      // Scheduled PWM level
    input wire logic       SHDN_COND,    // Shutdown condition
    input wire logic       CMP_SYNC_EN,  // Comparator sync enable
    input wire logic       TMR_SYNC,     // Timer sync pulse
    input wire logic       PWM_OUT,      // Delayed PWM level
    input wire logic       SHDN_STATE,   // Shutdown event flag
    input wire logic       IRQ           // Level interrupt
);
    timeunit 1ns;
    timeprecision 100ps;
    logic       rsen_r;
    logic [6:0] dc_r;
    logic [8:0] hi_r;
    wire        calm = !SHDN_COND && !CMP_SYNC_EN;
    wire  [8:0] dc4 = {dc_r, 2'b00};
    // Shadow of the control register, the checker cannot see it
    always @(posedge CLK) begin
        if (RST) begin
            rsen_r <= 1'b0;
            dc_r <= 7'h00;
        end else if (WR && ADDR == 4'h0) begin
            rsen_r <= WDATA[7];
            dc_r <= WDATA[6:0];
        end
        hi_r <= PWM_RAW ? hi_r + 9'h001 : 9'h000;
    end
    default clocking @(posedge CLK); endclocking
    default disable iff (RST);
    chk_entry_time: assert property (SHDN_COND && !CMP_SYNC_EN |-> ##2 SHDN_STATE)
        else $error("shutdown entry late");
    chk_sync_wait: assert property (CMP_SYNC_EN && $past(CMP_SYNC_EN) && !TMR_SYNC && !$past(TMR_SYNC)
        && !SHDN_STATE && !WR && !$past(RST) |=> !SHDN_STATE) else $error("shutdown entered off sync");
    chk_auto_clear: assert property (SHDN_STATE && rsen_r && calm && $past(calm) && !WR |=> !SHDN_STATE)
        else $error("auto restart missing");
    chk_manual_hold: assert property (SHDN_STATE && !rsen_r && !WR |=> SHDN_STATE)
        else $error("shutdown released without software");
    chk_sw_clear: assert property (WR && ADDR == 4'h1 && !WDATA[0] && calm && $past(calm) |=> !SHDN_STATE)
        else $error("software clear ignored");
    chk_zero_delay: assert property ($rose(PWM_RAW) && dc_r == 7'h00 && !SHDN_STATE && calm
        && $past(calm) && !WR ##1 PWM_RAW |-> ##[0:1] PWM_OUT) else $error("undelayed edge late");
    chk_delay_span: assert property ($rose(PWM_OUT) |-> hi_r + 9'h003 >= dc4 && hi_r <= dc4 + 9'h003)
        else $error("active edge delay wrong");
    chk_kill_out: assert property (SHDN_STATE |=> !PWM_OUT)
        else $error("output active in shutdown");
    chk_rdata_idle: assert property (!$past(RD) |-> RDATA == 8'h00)
        else $error("read data outside read cycle");
    cover property (SHDN_STATE && rsen_r ##1 !SHDN_STATE);
    cover property ($rose(PWM_OUT) && dc_r != 7'h00);
    cover property (CMP_SYNC_EN && TMR_SYNC && SHDN_COND);
endmodule
bind pwm_restart_delay pwm_restart_delay_assertions chk_i (.CLK, .RST, .ADDR, .WDATA, .WR, .RD, .RDATA,
    .PWM_RAW, .SHDN_COND, .CMP_SYNC_EN, .TMR_SYNC, .PWM_OUT, .SHDN_STATE, .IRQ);
`default_nettype wire

// ---- sim/pwm_restart_delay_bench.sv ----
// Self-checking bench for the PWM restart and delay block
`default_nettype none
module pwm_restart_delay_bench;
    timeunit 1ns;
    timeprecision 100ps;
    logic       CLK = 0, RST = 1, WR = 0, RD = 0, PWM_RAW = 0, SHDN_COND = 0, CMP_SYNC_EN = 0, TMR_SYNC = 0;
    logic [3:0] ADDR = 0;
    logic [7:0] WDATA = 0;
    wire  [7:0] RDATA, turn_ons;
    wire        PWM_OUT, SHDN_STATE, IRQ;
    wire  [2:0] obs = {IRQ, SHDN_STATE, PWM_OUT};
    int         errors = 0, checks_done = 0;
    pwm_restart_delay uut (.CLK, .RST, .ADDR, .WDATA, .WR, .RD, .RDATA, .PWM_RAW, .SHDN_COND,
        .CMP_SYNC_EN, .TMR_SYNC, .PWM_OUT, .SHDN_STATE, .IRQ);
    power_stage_model drv (.clk(CLK), .gate(PWM_OUT), .hold(SHDN_STATE), .turn_ons(turn_ons));
    initial forever #2.5 CLK = ~CLK;
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        ADDR <= a;
        WDATA <= d;
        WR <= 1'b1;
        @(posedge CLK);
        WR <= 1'b0;
        @(posedge CLK);
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        ADDR <= a;
        RD <= 1'b1;
        @(posedge CLK);
        RD <= 1'b0;
        #1 chk(RDATA, e);
        @(posedge CLK);
    endtask
    // Checks {IRQ, SHDN_STATE, PWM_OUT} off the edge, returns on an edge
    task automatic see(input int n, input logic [2:0] e);
        repeat (n) @(posedge CLK);
        #1 chk(8'(obs), 8'(e));
        @(posedge CLK);
    endtask
    task automatic end_sim;
        $display("errors %0d checks %0d", errors, checks_done);
        if (errors == 0 && checks_done > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial begin
        #5000 errors++;
        end_sim();
    end
    initial begin
        repeat (4) @(posedge CLK);
        RST <= 1'b0;
        rd(4'h0, 8'h00);
        wr(4'h0, 8'hff);
        rd(4'h0, 8'hff);
        rd(4'hf, 8'h00);
        wr(4'h0, 8'h00);
        PWM_RAW <= 1'b1;
        see(3, 3'b001);
        PWM_RAW <= 1'b0;
        see(2, 3'b000);
        wr(4'h0, 8'h03);
        PWM_RAW <= 1'b1;
        see(8, 3'b000);
        see(6, 3'b001);
        rd(4'h2, 8'h06);
        PWM_RAW <= 1'b0;
        chk(turn_ons, 8'h02);
        wr(4'h4, 8'h01);
        rd(4'h4, 8'h01);
        wr(4'h0, 8'h00);
        SHDN_COND <= 1'b1;
        see(4, 3'b110);
        rd(4'h2, 8'h01);
        SHDN_COND <= 1'b0;
        see(6, 3'b110);
        rd(4'h1, 8'h01);
        wr(4'h1, 8'h00);
        rd(4'h3, 8'h07);
        wr(4'h3, 8'h07);
        see(1, 3'b000);
        wr(4'h0, 8'h80);
        SHDN_COND <= 1'b1;
        see(4, 3'b110);
        SHDN_COND <= 1'b0;
        see(4, 3'b100);
        wr(4'h3, 8'h07);
        see(1, 3'b000);
        CMP_SYNC_EN <= 1'b1;
        SHDN_COND <= 1'b1;
        see(5, 3'b000);
        TMR_SYNC <= 1'b1;
        @(posedge CLK);
        TMR_SYNC <= 1'b0;
        see(3, 3'b110);
        // Reset in mid-run must clear a non-zero control word
        wr(4'h0, 8'h85);
        RST <= 1'b1;
        SHDN_COND <= 1'b0;
        CMP_SYNC_EN <= 1'b0;
        repeat (4) @(posedge CLK);
        RST <= 1'b0;
        rd(4'h0, 8'h00);
        see(0, 3'b000);
        // Software clear is refused while the condition is live
        SHDN_COND <= 1'b1;
        see(2, 3'b010);
        wr(4'h1, 8'h00);
        see(1, 3'b010);
        end_sim();
    end
endmodule
`default_nettype wire
